// ### hw/tws_eeprom.sv
// command engine of a three-wire serial eeprom with a 1k x 16 array
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_eeprom #(
  parameter int PROG_CYCLES = `TWS_PROG_TIME_US * `TWS_CLK_MHZ
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic select_pin,
  input  wire logic shift_clock_pin,
  input  wire logic serial_in_pin,
  input  wire logic low_supply_pin,
  output logic      serial_out_pin,
  output logic      serial_out_oe
);

  localparam int PROG_MAX_CYCLES = `TWS_PROG_MAX_US * `TWS_CLK_MHZ;

  typedef struct packed {
    logic [3:0]              s1;
    logic [3:0]              s2;
    logic [3:0]              s3;
    tws_pkg::tws_state_e     st;
    logic [`TWS_SR_W-1:0]    sr;
    logic [4:0]              cnt;
    logic [1:0]              lat_opc;
    logic [`TWS_ADDR_W-1:0]  lat_addr;
    logic [`TWS_ADDR_W-1:0]  rd_addr;
    logic [3:0]              bit_idx;
    logic                    so;
    logic                    so_oe;
    logic                    en;
    logic                    busy;
    logic                    vpend;
    logic [16:0]             timer;
    logic [`TWS_ADDR_W-1:0]  sweep;
    tws_pkg::tws_cmd_s       op;
  } tws_core_s;

  tws_core_s              cur;
  tws_core_s              nxt;
  logic [`TWS_DATA_W-1:0] mem [0:`TWS_WORDS-1];
  logic [`TWS_DATA_W-1:0] mem_rd;
  logic                   mem_we;
  logic [`TWS_ADDR_W-1:0] mem_wa;
  logic [`TWS_DATA_W-1:0] mem_wd;
  logic                   cs_h;
  logic                   cs_fall;
  logic                   sk_rise;
  logic                   di;
  logic                   low;
  logic [`TWS_SR_W-1:0]   sr_n;
  logic [4:0]             cnt_n;
  logic                   dec_ok;
  tws_pkg::tws_cmd_s      dec_cmd;
  logic                   push;
  logic                   buf_in_ready;
  logic                   buf_out_valid;
  logic                   buf_out_ready;
  tws_pkg::tws_cmd_s      buf_out_cmd;

  // pin levels after the two-flop synchroniser, edges from stage three
  assign cs_h    = cur.s2[`TWS_PIN_CS];
  assign cs_fall = ~cur.s2[`TWS_PIN_CS] & cur.s3[`TWS_PIN_CS];
  assign sk_rise = cur.s2[`TWS_PIN_SK] & ~cur.s3[`TWS_PIN_SK];
  assign di      = cur.s2[`TWS_PIN_DI];
  assign low     = cur.s2[`TWS_PIN_LOW];

  // serial input shift, sampled on shift clock rises
  assign sr_n  = {cur.sr[`TWS_SR_W-2:0], di};
  assign cnt_n = (cur.cnt == `TWS_CNT_SAT) ? cur.cnt : cur.cnt + 5'h01;
  assign mem_rd = mem[cur.rd_addr];

  // command decode with the clock-count monitor
  always_comb begin
    dec_cmd.addr = cur.lat_addr;
    dec_cmd.data = cur.sr[`TWS_DATA_W-1:0];
    dec_cmd.op   = tws_pkg::TWS_OP_WORD;
    dec_ok       = 1'b0;
    unique case (cur.lat_opc)
      `TWS_OPC_WRITE: begin
        dec_ok = (cur.cnt == `TWS_CNT_LONG);
      end
      `TWS_OPC_CLEAR: begin
        dec_cmd.op = tws_pkg::TWS_OP_CLEAR;
        dec_ok     = (cur.cnt == `TWS_CNT_SHORT);
      end
      `TWS_OPC_READ: begin
        dec_ok = 1'b0;
      end
      `TWS_OPC_EXT: begin
        unique case (cur.lat_addr[`TWS_ADDR_W-1 -: 2])
          `TWS_SUB_FILL: begin
            dec_cmd.op = tws_pkg::TWS_OP_FILL;
            dec_ok     = (cur.cnt == `TWS_CNT_LONG);
          end
          `TWS_SUB_CLRALL: begin
            dec_cmd.op = tws_pkg::TWS_OP_CLRALL;
            dec_ok     = (cur.cnt == `TWS_CNT_SHORT);
          end
          `TWS_SUB_UNLOCK: begin
            dec_cmd.op = tws_pkg::TWS_OP_UNLOCK;
            dec_ok     = (cur.cnt >= `TWS_CNT_SHORT);
          end
          `TWS_SUB_LOCK: begin
            dec_cmd.op = tws_pkg::TWS_OP_LOCK;
            dec_ok     = (cur.cnt >= `TWS_CNT_SHORT);
          end
        endcase
      end
    endcase
  end

  // a command is queued only when select falls ending its input
  assign push = (cur.st == tws_pkg::TWS_ST_SHIFT) && cs_fall && dec_ok
                && !low;
  assign buf_out_ready = !cur.busy;

  tws_buf u_buf (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_cmd    (dec_cmd),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_cmd   (buf_out_cmd)
  );

  // next-state logic: synchroniser, array engine, serial front end
  always_comb begin
    nxt    = cur;
    nxt.s1 = {low_supply_pin, serial_in_pin, shift_clock_pin, select_pin};
    nxt.s2 = cur.s1;
    nxt.s3 = cur.s2;
    mem_we = 1'b0;
    mem_wa = cur.op.addr;
    mem_wd = cur.op.data;

    // array engine: one word per cycle for whole-array operations
    if (cur.busy) begin
      if (low) begin
        nxt.busy = 1'b0;
      end else begin
        mem_we = 1'b1;
        if (cur.op.op == tws_pkg::TWS_OP_FILL ||
            cur.op.op == tws_pkg::TWS_OP_CLRALL) begin
          mem_wa    = cur.sweep;
          nxt.sweep = cur.sweep + 10'h001;
        end
        if (cur.timer == 17'h00000) begin
          nxt.busy = 1'b0;
        end else begin
          nxt.timer = cur.timer - 17'h00001;
        end
      end
    end else if (buf_out_valid && !low) begin
      unique case (buf_out_cmd.op)
        tws_pkg::TWS_OP_UNLOCK: begin
          nxt.en = 1'b1;
        end
        tws_pkg::TWS_OP_LOCK: begin
          nxt.en = 1'b0;
        end
        tws_pkg::TWS_OP_WORD, tws_pkg::TWS_OP_CLEAR,
        tws_pkg::TWS_OP_FILL, tws_pkg::TWS_OP_CLRALL: begin
          if (cur.en) begin
            nxt.busy  = 1'b1;
            nxt.timer = 17'(PROG_CYCLES - 1);
            nxt.op    = buf_out_cmd;
            nxt.sweep = '0;
            nxt.vpend = 1'b1;
            if (buf_out_cmd.op == tws_pkg::TWS_OP_CLEAR ||
                buf_out_cmd.op == tws_pkg::TWS_OP_CLRALL) begin
              nxt.op.data = `TWS_WORD_ONES;
            end
          end
        end
      endcase
    end
    if (low) begin
      nxt.en = 1'b0;
    end

    // serial front end
    unique case (cur.st)
      tws_pkg::TWS_ST_IDLE: begin
        if (cs_h) begin
          if (cur.vpend) begin
            nxt.st    = tws_pkg::TWS_ST_VERIFY;
            nxt.so_oe = 1'b1;
            nxt.so    = ~cur.busy;
          end else if (sk_rise && di && buf_in_ready) begin
            nxt.st  = tws_pkg::TWS_ST_SHIFT;
            nxt.cnt = '0;
            nxt.sr  = '0;
          end
        end
      end
      tws_pkg::TWS_ST_SHIFT: begin
        if (sk_rise) begin
          nxt.sr  = sr_n;
          nxt.cnt = cnt_n;
          if (cnt_n == `TWS_CNT_SHORT) begin
            nxt.lat_opc  = sr_n[`TWS_ADDR_W+1:`TWS_ADDR_W];
            nxt.lat_addr = sr_n[`TWS_ADDR_W-1:0];
            if (sr_n[`TWS_ADDR_W+1:`TWS_ADDR_W] == `TWS_OPC_READ) begin
              nxt.st      = tws_pkg::TWS_ST_READ;
              nxt.so_oe   = 1'b1;
              nxt.so      = 1'b0;
              nxt.rd_addr = sr_n[`TWS_ADDR_W-1:0];
              nxt.bit_idx = '0;
            end
          end
        end
      end
      tws_pkg::TWS_ST_READ: begin
        if (sk_rise) begin
          nxt.so      = mem_rd[~cur.bit_idx];
          nxt.bit_idx = cur.bit_idx + 4'h1;
          if (cur.bit_idx == `TWS_BIT_LAST) begin
            nxt.rd_addr = cur.rd_addr + 10'h001;
          end
        end
      end
      tws_pkg::TWS_ST_VERIFY: begin
        nxt.so_oe = 1'b1;
        nxt.so    = ~cur.busy;
        if (!cur.busy && sk_rise && di) begin
          nxt.st    = tws_pkg::TWS_ST_SHIFT;
          nxt.so_oe = 1'b0;
          nxt.so    = 1'b0;
          nxt.vpend = nxt.busy; // an operation starting now wins
          nxt.cnt   = '0;
          nxt.sr    = '0;
        end
      end
    endcase

    // deselect ends any phase and floats the output
    if (!cs_h) begin
      nxt.st    = tws_pkg::TWS_ST_IDLE;
      nxt.so_oe = 1'b0;
      nxt.so    = 1'b0;
    end
  end

  // state register; reset is power application with programming locked
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur    <= '0;
      cur.st <= tws_pkg::TWS_ST_IDLE;
    end else begin
      cur <= nxt;
    end
  end

  // cell array
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign serial_out_pin = cur.so;
  assign serial_out_oe  = cur.so_oe;

  // checks on the engine's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_start_bit: assert property (
    cur.st == tws_pkg::TWS_ST_IDLE && cs_h && sk_rise && di
    && !cur.vpend && buf_in_ready |=> cur.st == tws_pkg::TWS_ST_SHIFT)
    else $error("start bit not taken");

  chk_dummy_clk: assert property (
    cur.st == tws_pkg::TWS_ST_IDLE && sk_rise && !di && !cur.vpend
    |=> cur.st == tws_pkg::TWS_ST_IDLE)
    else $error("dummy clock left idle");

  chk_read_dummy: assert property (
    cur.st == tws_pkg::TWS_ST_READ
    && $past(cur.st) == tws_pkg::TWS_ST_SHIFT
    |-> cur.so_oe && !cur.so)
    else $error("fetch dummy bit not low");

  chk_read_wrap: assert property (
    cur.st == tws_pkg::TWS_ST_READ && cs_h && sk_rise
    && cur.bit_idx == `TWS_BIT_LAST && cur.rd_addr == 10'h3ff
    |=> cur.rd_addr == 10'h000)
    else $error("read address did not wrap");

  chk_count_cancel: assert property (
    cur.cnt > `TWS_CNT_LONG && cur.lat_opc != `TWS_OPC_EXT |-> !push)
    else $error("over-clocked program not cancelled");

  chk_lock_gate: assert property (
    !cur.busy && !cur.en |=> !cur.busy)
    else $error("program started while locked");

  chk_prog_time: assert property (
    cur.busy |-> cur.timer < 17'(PROG_MAX_CYCLES))
    else $error("program time beyond limit");

  chk_verify_out: assert property (
    cur.st == tws_pkg::TWS_ST_VERIFY
    && $past(cur.st) == tws_pkg::TWS_ST_VERIFY
    |-> cur.so_oe && cur.so == !$past(cur.busy))
    else $error("status output wrong");

  chk_ready_float: assert property (
    cur.st == tws_pkg::TWS_ST_VERIFY && !cur.busy && cs_h
    && sk_rise && di |=> !cur.so_oe ##1 cur.st != tws_pkg::TWS_ST_VERIFY)
    else $error("output not floated on start");

  chk_hiz_desel: assert property (
    !cs_h ##1 !cs_h |-> !cur.so_oe)
    else $error("output driven while deselected");

  chk_low_lock: assert property (
    low |=> !cur.en && !cur.busy)
    else $error("low supply did not lock");

  chk_busy_ignore: assert property (
    cur.busy && cur.st == tws_pkg::TWS_ST_VERIFY
    |=> cur.st != tws_pkg::TWS_ST_SHIFT)
    else $error("start taken while busy");

endmodule : tws_eeprom

// ### pkg/tws_regs.svh
// named constants of the three-wire serial eeprom command engine
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH

`define TWS_ADDR_W      10
`define TWS_DATA_W      16
`define TWS_SR_W        28
`define TWS_WORDS       1024

// positions of the synchronised pins
`define TWS_PIN_CS      0
`define TWS_PIN_SK      1
`define TWS_PIN_DI      2
`define TWS_PIN_LOW     3

// opcode patterns (replaceable encoding table)
`define TWS_OPC_EXT     2'h0
`define TWS_OPC_WRITE   2'h1
`define TWS_OPC_READ    2'h2
`define TWS_OPC_CLEAR   2'h3
`define TWS_SUB_LOCK    2'h0
`define TWS_SUB_FILL    2'h1
`define TWS_SUB_CLRALL  2'h2
`define TWS_SUB_UNLOCK  2'h3

// clock counts after the start bit, last bit index of a read word and the cleared word
`define TWS_CNT_SHORT   5'h0c
`define TWS_CNT_LONG    5'h1c
`define TWS_CNT_SAT     5'h1f
`define TWS_BIT_LAST    4'hf
`define TWS_WORD_ONES   16'hffff

// program time in microseconds and core clock in MHz
`define TWS_PROG_TIME_US 2000
`define TWS_PROG_MAX_US  4000
`define TWS_CLK_MHZ      20

`endif

// ### pkg/tws_pkg.sv
// types shared by the serial eeprom command engine and its buffer
`include "tws_regs.svh"
package tws_pkg;

  typedef enum logic [3:0] {
    TWS_ST_IDLE   = 4'h1,
    TWS_ST_SHIFT  = 4'h2,
    TWS_ST_READ   = 4'h4,
    TWS_ST_VERIFY = 4'h8
  } tws_state_e;

  typedef enum logic [2:0] {
    TWS_OP_WORD   = 3'h0,
    TWS_OP_CLEAR  = 3'h1,
    TWS_OP_FILL   = 3'h2,
    TWS_OP_CLRALL = 3'h3,
    TWS_OP_UNLOCK = 3'h4,
    TWS_OP_LOCK   = 3'h5
  } tws_op_e;

  typedef struct packed {
    tws_op_e                 op;
    logic [`TWS_ADDR_W-1:0]  addr;
    logic [`TWS_DATA_W-1:0]  data;
  } tws_cmd_s;

endpackage : tws_pkg

// ### hw/tws_buf.sv
// two-entry command buffer between the decoder and the array engine
`timescale 1ns/1ps
module tws_buf (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire tws_pkg::tws_cmd_s in_cmd,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output tws_pkg::tws_cmd_s      out_cmd
);

  typedef struct packed {
    tws_pkg::tws_cmd_s [1:0] ent;
    logic [1:0]              cnt;
    logic                    wp;
    logic                    rp;
  } tws_buf_s;

  tws_buf_s cur;
  tws_buf_s nxt;
  logic     push;
  logic     pop;

  // honest full and empty flags
  assign in_ready  = (cur.cnt != 2'h2);
  assign out_valid = (cur.cnt != 2'h0);
  assign out_cmd   = cur.ent[cur.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;

  // pointer and occupancy update
  always_comb begin
    nxt = cur;
    if (push) begin
      nxt.ent[cur.wp] = in_cmd;
      nxt.wp          = ~cur.wp;
    end
    if (pop) begin
      nxt.rp = ~cur.rp;
    end
    nxt.cnt = cur.cnt + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

endmodule : tws_buf

// ### test/tws_host.sv
// host controller model driving the three-wire link
`timescale 1ns/1ps
module tws_host (
  input  wire logic clk,
  output logic      select_pin,
  output logic      shift_clock_pin,
  output logic      serial_in_pin,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe
);
  // idle pins; clock stands low outside frames
  initial begin
    select_pin      = 1'b0;
    shift_clock_pin = 1'b0;
    serial_in_pin   = 1'b0;
  end

  // one clock period of 8 cycles; output sampled just before the rise
  task automatic pulse(input logic d, output logic q);
    serial_in_pin = d;
    repeat (4) @(negedge clk);
    q = serial_out_oe ? serial_out_pin : 1'bx;
    shift_clock_pin = 1'b1;
    repeat (4) @(negedge clk);
    shift_clock_pin = 1'b0;
  endtask : pulse

  // deselect past the deselect time; released input toggles, no stale level
  task automatic end_frame();
    select_pin = 1'b0;
    repeat (6) begin
      serial_in_pin = ~serial_in_pin;
      @(negedge clk);
    end
  endtask : end_frame

  // n bits msb first, then nrd read clocks; rd holds dummy plus data
  task automatic frame(input logic [63:0] b, input int n, input int nrd,
                       output logic [63:0] rd);
    logic q;
    rd = '0;
    select_pin    = 1'b1;
    serial_in_pin = 1'b0;
    repeat (2) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) pulse(b[i], q);
    for (int i = 0; i < nrd; i++) begin
      pulse(1'b0, q);
      rd = {rd[62:0], q};
    end
    repeat (4) @(negedge clk);
    rd = {rd[62:0], serial_out_oe ? serial_out_pin : 1'bx};
    end_frame();
  endtask : frame

  // raise select with input low and wait while busy is shown
  task automatic poll(input int lim, output int busy, output logic rdy);
    select_pin    = 1'b1;
    serial_in_pin = 1'b0;
    busy          = 0;
    repeat (4) @(negedge clk);
    while (serial_out_oe === 1'b1 && serial_out_pin === 1'b0 &&
           busy < lim) begin
      busy++;
      @(negedge clk);
    end
    rdy = (serial_out_oe === 1'b1) && (serial_out_pin === 1'b1);
  endtask : poll
endmodule : tws_host

// ### test/test_three_wire_serial_eeprom_protocol.sv
// self-checking bench for the serial eeprom command engine
`timescale 1ns/1ps
`include "tws_regs.svh"
module test_three_wire_serial_eeprom_protocol;
  localparam int PC = 1100;
  logic        clk;
  logic        resetn;
  logic        low_supply_pin;
  logic        select_pin;
  logic        shift_clock_pin;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic        serial_out_oe;
  logic [31:0] seed;
  int          n_errors;
  int          checked;
  logic [15:0] shadow [0:1023];
  logic [63:0] rd;
  logic [9:0]  a;
  logic [15:0] d;
  logic        q;
  int          bz;

  tws_eeprom #(.PROG_CYCLES(PC)) u_dut (
    .clk             (clk),
    .resetn          (resetn),
    .select_pin      (select_pin),
    .shift_clock_pin (shift_clock_pin),
    .serial_in_pin   (serial_in_pin),
    .low_supply_pin  (low_supply_pin),
    .serial_out_pin  (serial_out_pin),
    .serial_out_oe   (serial_out_oe)
  );

  tws_host u_host (
    .clk             (clk),
    .select_pin      (select_pin),
    .shift_clock_pin (shift_clock_pin),
    .serial_in_pin   (serial_in_pin),
    .serial_out_pin  (serial_out_pin),
    .serial_out_oe   (serial_out_oe)
  );

  // 20 mhz core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // start bit, opcode, address, optional data
  function automatic logic [63:0] cmd(logic [1:0] op, logic [9:0] ad,
                                      logic [15:0] dt, logic wd);
    return wd ? {35'h0, 1'b1, op, ad, dt} : {51'h0, 1'b1, op, ad};
  endfunction : cmd

  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // send a program command; when act is set poll once early, then until ready
  task automatic prog(input logic [63:0] b, input int n, input logic act);
    int   bz;
    logic rdy;
    u_host.frame(b, n, 0, rd);
    if (act) begin
      u_host.poll(40, bz, rdy);
      chk("busy shown", 64'h1, 64'(bz == 40));
      u_host.end_frame();
    end
    u_host.poll(2 * PC, bz, rdy);
    chk("ready", 64'(act), 64'(rdy));
    u_host.end_frame();
  endtask : prog

  // read nw words from ad and compare dummy bit and data
  task automatic rdw(input logic [9:0] ad, input int nw);
    logic [9:0] ix;
    u_host.frame(cmd(`TWS_OPC_READ, ad, 16'h0, 1'b0), 13, 16 * nw, rd);
    chk("dummy bit", 64'h0, 64'(rd[16 * nw]));
    for (int w = 0; w < nw; w++) begin
      ix = ad + 10'(w);
      chk("word", 64'(shadow[ix]), 64'(rd[16 * (nw - 1 - w) +: 16]));
    end
  endtask : rdw

  task automatic ext(input logic [1:0] sub, input int pad);
    u_host.frame(cmd(`TWS_OPC_EXT, {sub, 8'h5a}, 16'h0, 1'b0), 13 + pad,
                 0, rd);
  endtask : ext

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    seed           = 32'h66ba4195;
    n_errors       = 0;
    checked        = 0;
    resetn         = 1'b0;
    low_supply_pin = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    ext(`TWS_SUB_UNLOCK, 3);
    d = 16'(rnd());
    prog(cmd(`TWS_OPC_EXT, {`TWS_SUB_FILL, 8'(rnd())}, d, 1'b1), 29, 1'b1);
    foreach (shadow[i]) shadow[i] = d;
    rdw(10'(rnd()), 1);
    $display("fill and read done");
    for (int k = 0; k < 3; k++) begin
      a = 10'(rnd());
      d = 16'(rnd());
      prog(cmd(`TWS_OPC_WRITE, a, d, 1'b1), 29, 1'b1);
      shadow[a] = d;
      rdw(a, 1);
    end
    prog(cmd(`TWS_OPC_WRITE, a, d, 1'b1), 29, 1'b1);
    u_host.poll(20, bz, q);
    chk("ready on reselect", 64'h1, 64'(q));
    u_host.pulse(1'b1, q);
    chk("float on start", 64'h0, 64'(serial_out_oe));
    u_host.end_frame();
    $display("word write done");
    shadow[10'h3ff] = 16'(rnd());
    shadow[10'h000] = 16'(rnd());
    prog(cmd(`TWS_OPC_WRITE, 10'h3ff, shadow[10'h3ff], 1'b1), 29, 1'b1);
    prog(cmd(`TWS_OPC_WRITE, 10'h000, shadow[10'h000], 1'b1), 29, 1'b1);
    rdw(10'h3ff, 2);
    $display("wrap read done");
    a = 10'(rnd());
    prog(cmd(`TWS_OPC_CLEAR, a, 16'h0, 1'b0), 13, 1'b1);
    shadow[a] = 16'hffff;
    rdw(a, 1);
    prog(cmd(`TWS_OPC_WRITE, a, 16'h1234, 1'b1) << 1, 30, 1'b0);
    prog(cmd(`TWS_OPC_CLEAR, a + 10'h1, 16'h0, 1'b0) << 1, 14, 1'b0);
    rdw(a, 2);
    $display("clear and overcount done");
    ext(`TWS_SUB_LOCK, 0);
    prog(cmd(`TWS_OPC_WRITE, a, 16'h0f0f, 1'b1), 29, 1'b0);
    prog(cmd(`TWS_OPC_EXT, {`TWS_SUB_CLRALL, 8'h0}, 16'h0, 1'b0), 13, 1'b0);
    rdw(a, 1);
    ext(`TWS_SUB_UNLOCK, 0);
    prog(cmd(`TWS_OPC_EXT, {`TWS_SUB_CLRALL, 8'h0}, 16'h0, 1'b0), 13, 1'b1);
    foreach (shadow[i]) shadow[i] = 16'hffff;
    rdw(10'(rnd()), 2);
    $display("lock and clear-all done");
    ext(`TWS_SUB_UNLOCK, 0);
    low_supply_pin = 1'b1;
    repeat (4) @(negedge clk);
    low_supply_pin = 1'b0;
    repeat (4) @(negedge clk);
    prog(cmd(`TWS_OPC_WRITE, a, 16'h00ff, 1'b1), 29, 1'b0);
    ext(`TWS_SUB_UNLOCK, 0);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    prog(cmd(`TWS_OPC_WRITE, a, 16'h00ff, 1'b1), 29, 1'b0);
    rdw(a, 1);
    $display("low supply and reset done");
    wrap_up();
  end
endmodule : test_three_wire_serial_eeprom_protocol
